// ==== bench/fqc_host_model.sv ====
`timescale 1ns/1ps
module fqc_host_model
(
    input  wire logic               mclk,
    output logic                    reg_wr,
    output logic                    reg_rd,
    output fqc_pkg::fqc_addr_t      reg_addr,
    output logic [1:0]              reg_be,
    output fqc_pkg::fqc_word_t      reg_wdata,
    input  wire fqc_pkg::fqc_word_t reg_rdata
);
    import fqc_pkg::*;
    initial {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = '0;
    // One access per call; idle bus shows inverted leftovers
    task automatic go(input logic w, input fqc_addr_t a, input logic [1:0] be, input fqc_word_t d);
        @(negedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = {w, !w, a, be, d};
        @(negedge mclk);
        {reg_wr, reg_rd, reg_be} = '0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic wr(input fqc_addr_t a, input logic [1:0] be, input fqc_word_t d);
        go(1'b1, a, be, d);
    endtask
    task automatic rd(input fqc_addr_t a, output fqc_word_t d);
        go(1'b0, a, 2'b11, 16'hA5A5);
        d = reg_rdata;
    endtask
endmodule // fqc_host_model

// ==== bench/fqc_top_assertions.sv ====
`timescale 1ns/1ps
module fqc_top_assertions
(
    input wire logic               mclk,
    input wire logic               rst_n,
    input wire logic               ce,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire fqc_pkg::fqc_addr_t reg_addr,
    input wire logic [1:0]         reg_be,
    input wire fqc_pkg::fqc_word_t reg_wdata,
    input wire logic               reg_refused,
    input wire logic               fifo_session,
    input wire logic               tx_frame_ready,
    input wire logic               tx_enqueue,
    input wire logic               tx_ptr_reload,
    input wire logic               rx_frame_read_done,
    input wire logic               rx_dequeue,
    input wire logic               rx_release_req,
    input wire logic               rx_release_done
);
    import fqc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire rel_wr = ce && reg_wr && reg_addr[7:1] == 7'h41 && reg_be[0] && reg_wdata[0];
    sequence s_wr82;
        ce && reg_wr && reg_addr[7:1] == 7'h41 && reg_be[0];
    endsequence
    AST_REFUSE: assert property (reg_refused == ((reg_wr || reg_rd) && fifo_session && reg_addr[7:1] != 7'h41))
        else $error("refusal flag wrong");
    AST_SESSION: assert property (s_wr82 |=> fifo_session == $past(reg_wdata[3]))
        else $error("session level wrong");
    AST_REL_SET: assert property (rel_wr |=> rx_release_req)
        else $error("release not requested");
    AST_REL_HOLD: assert property (ce && rx_release_req && !rx_release_done |=> rx_release_req)
        else $error("release dropped early");
    AST_REL_CLR: assert property (ce && rx_release_done && !rel_wr |=> !rx_release_req)
        else $error("release not cleared");
    AST_DEQ: assert property (rx_dequeue |-> $past(rx_frame_read_done))
        else $error("dequeue without read done");
    AST_PTR: assert property (tx_enqueue == tx_ptr_reload)
        else $error("pointer reload not with enqueue");
    AST_ENQ_CAUSE: assert property (tx_enqueue |-> $past(tx_frame_ready) || $past(reg_wr))
        else $error("enqueue without cause");
endmodule // fqc_top_assertions

bind fqc_top fqc_top_assertions u_chk (.mclk, .rst_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_be, .reg_wdata,
    .reg_refused, .fifo_session, .tx_frame_ready, .tx_enqueue, .tx_ptr_reload, .rx_frame_read_done,
    .rx_dequeue, .rx_release_req, .rx_release_done);

// ==== bench/fqc_top_test.sv ====
`timescale 1ns/1ps
module fqc_top_test;
    import fqc_pkg::*;
    logic mclk, rst_n, ce, reg_wr, reg_rd, reg_refused, fifo_session, tx_frame_ready, tx_frame_done;
    logic tx_enqueue, tx_ptr_reload, tx_mem_avail_irq, status_rx_refresh, rx_thresh_irq, rx_align_offset_enable;
    logic rx_frame_read_done, rx_dequeue, rx_release_req, rx_release_done;
    logic [1:0]  reg_be;
    fqc_addr_t   reg_addr;
    fqc_word_t   reg_wdata, reg_rdata, rd_val;
    fqc_space_t  tx_free_space, tx_space_request;
    logic [15:0] dur_thresh, byte_thresh, frame_thresh, rx_byte_count, rx_frame_count;
    int          num_errors, compares, n_enq, n_mirq, n_rirq, n_ref;

    fqc_top u_dut (.mclk, .rst_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_be, .reg_wdata, .reg_rdata,
        .reg_refused, .fifo_session, .tx_frame_ready, .tx_frame_done, .tx_free_space, .tx_space_request,
        .tx_enqueue, .tx_ptr_reload, .tx_mem_avail_irq, .status_rx_refresh, .dur_thresh, .byte_thresh,
        .frame_thresh, .rx_byte_count, .rx_frame_count, .rx_thresh_irq, .rx_align_offset_enable,
        .rx_frame_read_done, .rx_dequeue, .rx_release_req, .rx_release_done);
    fqc_host_model u_host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_be, .reg_wdata, .reg_rdata);

    always @(posedge mclk)
    begin
        n_enq <= n_enq + int'(tx_enqueue === 1'b1);
        n_mirq <= n_mirq + int'(tx_mem_avail_irq === 1'b1);
        n_rirq <= n_rirq + int'(rx_thresh_irq === 1'b1);
        n_ref <= n_ref + int'(reg_refused === 1'b1);
    end

    task automatic chk(input fqc_word_t got, input fqc_word_t exp, input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rchk(input fqc_addr_t a, input fqc_word_t exp, input string what);
        u_host.rd(a, rd_val);
        chk(rd_val, exp, what);
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk) s = 1'b1;
        @(negedge mclk) s = 1'b0;
    endtask
    task automatic print_verdict;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_manual;
        rchk(8'h80, 16'h0000, "tx reset");
        u_host.wr(8'h80, 2'b01, 16'h0001);
        chk(16'(tx_enqueue), 16'h0001, "enqueue");
        chk(16'(tx_ptr_reload), 16'h0001, "pointer reload");
        rchk(8'h80, 16'h0001, "manual pending");
        u_host.wr(8'h80, 2'b01, 16'h0001);
        chk(16'(n_enq), 16'h0001, "one frame");
        pulse(tx_frame_done);
        rchk(8'h80, 16'h0000, "manual cleared");
        $display("manual enqueue done");
    endtask
    task automatic t_auto;
        int b;
        b = n_enq;
        rchk(8'h80, 16'h0000, "manual idle before prep");
        u_host.wr(8'h80, 2'b01, 16'h0004);
        pulse(tx_frame_ready);
        chk(16'(tx_enqueue), 16'h0001, "auto enqueue");
        pulse(tx_frame_ready);
        pulse(tx_frame_done);
        chk(16'(n_enq - b), 16'h0002, "auto count");
        u_host.wr(8'h80, 2'b01, 16'h0000);
        $display("auto enqueue done");
    endtask
    task automatic t_monitor;
        {tx_space_request, tx_free_space} = {13'h0100, 13'h0080};
        u_host.wr(8'h80, 2'b01, 16'h0002);
        repeat (4) @(negedge mclk);
        chk(16'(n_mirq), 16'h0000, "no space yet");
        tx_free_space = 13'h0100;
        repeat (4) @(negedge mclk);
        chk(16'(n_mirq), 16'h0001, "space irq once");
        rchk(8'h80, 16'h0002, "monitor pending");
        pulse(tx_frame_done);
        rchk(8'h80, 16'h0000, "monitor cleared");
        $display("memory monitor done");
    endtask
    task automatic t_dequeue;
        u_host.wr(8'h82, 2'b01, 16'h0010);
        pulse(rx_frame_read_done);
        chk(16'(rx_dequeue), 16'h0001, "dequeue");
        u_host.wr(8'h82, 2'b01, 16'h0000);
        pulse(rx_frame_read_done);
        chk(16'(rx_dequeue), 16'h0000, "no dequeue");
        $display("auto dequeue done");
    endtask
    task automatic t_session;
        u_host.wr(8'h82, 2'b01, 16'h0008);
        chk(16'(fifo_session), 16'h0001, "session open");
        u_host.wr(8'h80, 2'b01, 16'h0001);
        chk(16'(tx_enqueue), 16'h0000, "refused write");
        rchk(8'h80, 16'h0000, "refused read");
        rchk(8'h82, 16'h0000, "bit 3 reads 0");
        chk(16'(n_ref), 16'h0002, "refusals");
        u_host.wr(8'h82, 2'b01, 16'h0000);
        rchk(8'h90, 16'h0000, "unmapped");
        chk(16'(n_ref), 16'h0002, "not refused");
        $display("bulk session done");
    endtask
    task automatic t_release;
        u_host.wr(8'h82, 2'b01, 16'h0001);
        chk(16'(rx_release_req), 16'h0001, "release request");
        rchk(8'h82, 16'h0001, "release pending");
        pulse(rx_release_done);
        chk(16'(rx_release_req), 16'h0000, "release dropped");
        rchk(8'h82, 16'h0000, "release cleared");
        $display("error release done");
    endtask
    task automatic t_freeze;
        ce = 1'b0;
        u_host.wr(8'h82, 2'b01, 16'h0010);
        ce = 1'b1;
        rchk(8'h82, 16'h0000, "frozen write");
        $display("clock enable done");
    endtask
    task automatic t_thresh;
        {frame_thresh, byte_thresh, dur_thresh} = {16'h0002, 16'h000A, 16'hFFFF};
        {rx_frame_count, rx_byte_count} = {16'h0003, 16'h000A};
        u_host.wr(8'h82, 2'b11, 16'h02E0);
        chk(16'(rx_align_offset_enable), 16'h0001, "align");
        pulse(status_rx_refresh);
        rchk(8'h82, 16'h06E0, "frame cause");
        {rx_byte_count, dur_thresh} = {16'h000B, 16'h0002};
        repeat (40) @(negedge mclk);
        rchk(8'h82, 16'h06E0, "causes held");
        pulse(status_rx_refresh);
        rchk(8'h82, 16'h1EE0, "all causes");
        chk(16'(n_rirq), 16'h0003, "irq per cause");
        $display("rx thresholds done");
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        #2000000;
        num_errors++;
        print_verdict;
    end
    initial
    begin
        {rst_n, tx_frame_ready, tx_frame_done, status_rx_refresh, rx_frame_read_done, rx_release_done} = '0;
        ce = 1'b1;
        {tx_free_space, tx_space_request} = '0;
        {dur_thresh, byte_thresh, frame_thresh, rx_byte_count, rx_frame_count} = '0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        t_manual;
        t_auto;
        t_monitor;
        t_dequeue;
        t_session;
        t_release;
        t_freeze;
        t_thresh;
        print_verdict;
    end
endmodule // fqc_top_test

// ==== hdl/fqc_pkg.sv ====
package fqc_pkg;

    typedef logic [7:0]  fqc_addr_t;
    typedef logic [15:0] fqc_word_t;
    typedef logic [12:0] fqc_space_t;
    typedef logic [2:0]  fqc_cause_t;

    typedef enum logic [1:0]
    {
        FQC_TX_IDLE = 2'b01,
        FQC_TX_BUSY = 2'b10
    } fqc_tx_state_t;

endpackage

// ==== hdl/fqc_regs.svh ====
`ifndef FQC_REGS_SVH
`define FQC_REGS_SVH

// Register byte addresses
`define FQC_TX_CMD_ADDR      8'h80
`define FQC_RX_CMD_ADDR      8'h82

// Transmit queue command fields
`define FQC_TX_MANUAL_BIT    0
`define FQC_TX_MONITOR_BIT   1
`define FQC_TX_AUTO_BIT      2

// Receive queue command fields
`define FQC_RX_RELEASE_BIT   0
`define FQC_RX_DMA_BIT       3
`define FQC_RX_ADEQ_BIT      4
`define FQC_RX_FRAME_EN_BIT  5
`define FQC_RX_BYTE_EN_BIT   6
`define FQC_RX_DUR_EN_BIT    7
`define FQC_RX_ALIGN_BIT     9
`define FQC_RX_CAUSE_LSB     10

// Reset values
`define FQC_TX_CMD_RESET     16'h0000
`define FQC_RX_CMD_RESET     16'h0000

// Duration timer tick: 1 us at a 100 ns clock, rounded up
`define FQC_CLK_PERIOD_NS    100
`define FQC_TICK_NS          1000
`define FQC_TICK_CYCLES      ((`FQC_TICK_NS + `FQC_CLK_PERIOD_NS - 1) / `FQC_CLK_PERIOD_NS)

`endif

// ==== hdl/fqc_rx_thresh.sv ====
`timescale 1ns/1ps
`include "fqc_regs.svh"
module fqc_rx_thresh
(
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    fqc_rxth_if.th             th,
    input  wire logic [15:0]   dur_thresh,
    input  wire logic [15:0]   byte_thresh,
    input  wire logic [15:0]   frame_thresh,
    input  wire logic [15:0]   rx_byte_count,
    input  wire logic [15:0]   rx_frame_count
);
    import fqc_pkg::*;

    localparam logic [3:0] TICK_LAST = 4'(`FQC_TICK_CYCLES - 1);

    logic [3:0]  pre_q,   pre_d;
    logic [15:0] us_q,    us_d;
    fqc_cause_t  cause_q, cause_d;
    fqc_cause_t  hit_q,   hit_d;
    logic        irq_q,   irq_d;
    fqc_cause_t  live;

    always_comb
    begin
        // Timer runs only while at least one frame waits in the queue
        live[2] = th.dur_en   && (us_q > dur_thresh);                 // R11
        live[1] = th.byte_en  && (rx_byte_count > byte_thresh);       // R12
        live[0] = th.frame_en && (rx_frame_count > frame_thresh);     // R13
        pre_d   = pre_q;
        us_d    = us_q;
        if (rx_frame_count == 16'h0000)
        begin
            pre_d = 4'h0;
            us_d  = 16'h0000;
        end
        else if (pre_q == TICK_LAST)
        begin
            pre_d = 4'h0;
            if (us_q != 16'hFFFF)
                us_d = us_q + 16'h0001;
        end
        else
            pre_d = pre_q + 4'h1;
        hit_d   = live;
        irq_d   = |(live & ~hit_q);
        cause_d = th.refresh ? live : cause_q;                       // R09
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q   <= 4'h0;
            us_q    <= 16'h0000;
            cause_q <= 3'h0;
            hit_q   <= 3'h0;
            irq_q   <= 1'b0;
        end
        else if (ce)
        begin
            pre_q   <= pre_d;
            us_q    <= us_d;
            cause_q <= cause_d;
            hit_q   <= hit_d;
            irq_q   <= irq_d;
        end
    end

    assign th.cause = cause_q; // R08
    assign th.irq   = irq_q;
endmodule // fqc_rx_thresh

// ==== hdl/fqc_rxth_if.sv ====
`timescale 1ns/1ps
interface fqc_rxth_if;
    import fqc_pkg::*;

    logic       dur_en;
    logic       byte_en;
    logic       frame_en;
    logic       refresh;
    fqc_cause_t cause;
    logic       irq;

    modport ctl (output dur_en, output byte_en, output frame_en, output refresh, input cause, input irq);
    modport th  (input dur_en, input byte_en, input frame_en, input refresh, output cause, output irq);
endinterface

// ==== hdl/fqc_top.sv ====
`timescale 1ns/1ps
`include "fqc_regs.svh"
// Functional notes
// R01 - Command write hands prepared frame to queue
// R02 - Auto bit queues every prepared frame
// R03 - Host keeps manual bit clear under auto
// R04 - Monitor raises status bit 6 on space
// R05 - Monitor self-clears after frame sent
// R06 - Manual bit queues one frame, self-clears
// R07 - Host waits manual bit clear before preparing
// R08 - Three read-only receive cause flags
// R09 - Cause flags refresh on status bit 13
// R10 - Align bit inserts two header bytes
// R11 - Duration threshold raises receive interrupt
// R12 - Byte count threshold raises receive interrupt
// R13 - Frame count threshold raises receive interrupt
// R14 - Auto dequeue advances read pointer
// R15 - Bulk bit opens FIFO burst session
// R16 - Session refuses all other registers
// R17 - Host clears bulk bit before other access
// R18 - Release bit frees errored frame, self-clears
// R19 - Host waits release clear before new frame
// R20 - Enqueue reloads transmit data pointer
// R21 - Host zeroes receive pointer before bulk read
// R22 - Self-clearing bits read 1 while pending
module fqc_top
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire fqc_pkg::fqc_addr_t reg_addr,
    input  wire logic [1:0]        reg_be,
    input  wire fqc_pkg::fqc_word_t reg_wdata,
    output      fqc_pkg::fqc_word_t reg_rdata,
    output      logic              reg_refused,
    output      logic              fifo_session,
    input  wire logic              tx_frame_ready,
    input  wire logic              tx_frame_done,
    input  wire fqc_pkg::fqc_space_t tx_free_space,
    input  wire fqc_pkg::fqc_space_t tx_space_request,
    output      logic              tx_enqueue,
    output      logic              tx_ptr_reload,
    output      logic              tx_mem_avail_irq,
    input  wire logic              status_rx_refresh,
    input  wire logic [15:0]       dur_thresh,
    input  wire logic [15:0]       byte_thresh,
    input  wire logic [15:0]       frame_thresh,
    input  wire logic [15:0]       rx_byte_count,
    input  wire logic [15:0]       rx_frame_count,
    output      logic              rx_thresh_irq,
    output      logic              rx_align_offset_enable,
    input  wire logic              rx_frame_read_done,
    output      logic              rx_dequeue,
    output      logic              rx_release_req,
    input  wire logic              rx_release_done
);
    import fqc_pkg::*;

    fqc_rxth_if rxth ();

    fqc_tx_state_t tx_state_q, tx_state_d;
    logic      auto_q,   auto_d;
    logic      mon_q,    mon_d;
    logic      fired_q,  fired_d;
    logic      enq_q,    enq_d;
    logic      mirq_q,   mirq_d;
    logic      align_q,  align_d;
    logic      dur_q,    dur_d;
    logic      byte_q,   byte_d;
    logic      frame_q,  frame_d;
    logic      adeq_q,   adeq_d;
    logic      dma_q,    dma_d;
    logic      rel_q,    rel_d;
    logic      deq_q,    deq_d;
    fqc_word_t rdata_q,  rdata_d;
    logic      hit_tx;
    logic      hit_rx;
    logic      refuse;
    logic      wr_tx;
    logic      wr_rx_lo;
    logic      wr_rx_hi;
    logic      man_req;
    fqc_word_t tx_view;
    fqc_word_t rx_view;

    // Decode; while a FIFO session is open only the receive command word is reachable
    always_comb
    begin
        hit_tx   = (reg_addr[7:1] == 7'(`FQC_TX_CMD_ADDR >> 1));
        hit_rx   = (reg_addr[7:1] == 7'(`FQC_RX_CMD_ADDR >> 1));
        refuse   = dma_q && !hit_rx && (reg_wr || reg_rd); // R16
        wr_tx    = reg_wr && hit_tx && !dma_q && reg_be[0];
        wr_rx_lo = reg_wr && hit_rx && reg_be[0];
        wr_rx_hi = reg_wr && hit_rx && reg_be[1];
        man_req  = wr_tx && reg_wdata[`FQC_TX_MANUAL_BIT];
        tx_view  = 16'h0000;
        tx_view[`FQC_TX_MANUAL_BIT]  = (tx_state_q == FQC_TX_BUSY); // R22
        tx_view[`FQC_TX_MONITOR_BIT] = mon_q;
        tx_view[`FQC_TX_AUTO_BIT]    = auto_q;
        rx_view  = 16'h0000;
        rx_view[`FQC_RX_CAUSE_LSB +: 3] = rxth.cause; // R08
        rx_view[`FQC_RX_ALIGN_BIT]      = align_q;
        rx_view[`FQC_RX_DUR_EN_BIT]     = dur_q;
        rx_view[`FQC_RX_BYTE_EN_BIT]    = byte_q;
        rx_view[`FQC_RX_FRAME_EN_BIT]   = frame_q;
        rx_view[`FQC_RX_ADEQ_BIT]       = adeq_q;
        rx_view[`FQC_RX_RELEASE_BIT]    = rel_q; // R22
    end

    // Transmit queue command
    always_comb
    begin
        tx_state_d = tx_state_q;
        auto_d     = auto_q;
        mon_d      = mon_q;
        fired_d    = fired_q;
        enq_d      = 1'b0;
        mirq_d     = 1'b0;
        case (tx_state_q)
            FQC_TX_IDLE:
            begin
                if (man_req)
                begin
                    tx_state_d = FQC_TX_BUSY;
                    enq_d      = 1'b1; // R01
                end
            end
            FQC_TX_BUSY:
            begin
                if (tx_frame_done)
                    tx_state_d = FQC_TX_IDLE; // R06
            end
            default:
                tx_state_d = FQC_TX_IDLE;
        endcase
        if (auto_q && tx_frame_ready)
            enq_d = 1'b1; // R02
        if (wr_tx)
            auto_d = reg_wdata[`FQC_TX_AUTO_BIT];
        if (tx_frame_done)
            mon_d = 1'b0; // R05
        if (wr_tx && reg_wdata[`FQC_TX_MONITOR_BIT])
        begin
            mon_d   = 1'b1;
            fired_d = 1'b0;
        end
        else if (mon_q && !fired_q && (tx_free_space >= tx_space_request))
        begin
            mirq_d  = 1'b1; // R04
            fired_d = 1'b1;
        end
    end

    // Receive queue command and read data
    always_comb
    begin
        align_d = align_q;
        dur_d   = dur_q;
        byte_d  = byte_q;
        frame_d = frame_q;
        adeq_d  = adeq_q;
        dma_d   = dma_q;
        rel_d   = rel_q;
        deq_d   = adeq_q && rx_frame_read_done; // R14
        if (rx_release_done)
            rel_d = 1'b0;
        if (wr_rx_lo)
        begin
            dur_d   = reg_wdata[`FQC_RX_DUR_EN_BIT];
            byte_d  = reg_wdata[`FQC_RX_BYTE_EN_BIT];
            frame_d = reg_wdata[`FQC_RX_FRAME_EN_BIT];
            adeq_d  = reg_wdata[`FQC_RX_ADEQ_BIT];
            dma_d   = reg_wdata[`FQC_RX_DMA_BIT]; // R15
            if (reg_wdata[`FQC_RX_RELEASE_BIT])
                rel_d = 1'b1; // R18
        end
        if (wr_rx_hi)
            align_d = reg_wdata[`FQC_RX_ALIGN_BIT]; // R10
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            if (hit_rx)
                rdata_d = rx_view;
            else if (hit_tx && !dma_q)
                rdata_d = tx_view;
            else
                rdata_d = 16'h0000;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state_q <= FQC_TX_IDLE;
            auto_q     <= 1'((`FQC_TX_CMD_RESET >> `FQC_TX_AUTO_BIT) & 16'h0001);
            mon_q      <= 1'b0;
            fired_q    <= 1'b0;
            enq_q      <= 1'b0;
            mirq_q     <= 1'b0;
            align_q    <= 1'b0;
            dur_q      <= 1'b0;
            byte_q     <= 1'b0;
            frame_q    <= 1'b0;
            adeq_q     <= 1'b0;
            dma_q      <= 1'b0;
            rel_q      <= 1'b0;
            deq_q      <= 1'b0;
            rdata_q    <= `FQC_RX_CMD_RESET;
        end
        else if (ce)
        begin
            tx_state_q <= tx_state_d;
            auto_q     <= auto_d;
            mon_q      <= mon_d;
            fired_q    <= fired_d;
            enq_q      <= enq_d;
            mirq_q     <= mirq_d;
            align_q    <= align_d;
            dur_q      <= dur_d;
            byte_q     <= byte_d;
            frame_q    <= frame_d;
            adeq_q     <= adeq_d;
            dma_q      <= dma_d;
            rel_q      <= rel_d;
            deq_q      <= deq_d;
            rdata_q    <= rdata_d;
        end
    end

    assign rxth.dur_en   = dur_q;
    assign rxth.byte_en  = byte_q;
    assign rxth.frame_en = frame_q;
    assign rxth.refresh  = status_rx_refresh && ce;

    fqc_rx_thresh u_rx_thresh
    (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .ce             (ce),
        .th             (rxth),
        .dur_thresh     (dur_thresh),
        .byte_thresh    (byte_thresh),
        .frame_thresh   (frame_thresh),
        .rx_byte_count  (rx_byte_count),
        .rx_frame_count (rx_frame_count)
    );

    assign reg_rdata              = rdata_q;
    assign reg_refused            = refuse;
    assign fifo_session           = dma_q;
    assign tx_enqueue             = enq_q;
    assign tx_ptr_reload          = enq_q; // R20
    assign tx_mem_avail_irq       = mirq_q;
    assign rx_thresh_irq          = rxth.irq;
    assign rx_align_offset_enable = align_q;
    assign rx_dequeue             = deq_q;
    assign rx_release_req         = rel_q;
endmodule // fqc_top
